// >>> verilog/ulf_pkg.sv
// constants for the serial line format control block
`default_nettype none
package ulf_pkg;
  // register byte offsets on the apb window
  localparam logic [7:0] OFS_DATA   = 8'h00; // tx holding / rx buffer, or divisor low
  localparam logic [7:0] OFS_IER    = 8'h04; // interrupt enable, or divisor high
  localparam logic [7:0] OFS_LFC    = 8'h0C; // line_format_control
  localparam logic [7:0] OFS_STATUS = 8'h14; // live status, read clears error flags
  // line_format_control field positions
  localparam int LFC_DAS   = 7; // divisor_access_select
  localparam int LFC_BRK   = 6; // break_force
  localparam int LFC_STICK = 5; // stick_parity
  localparam int LFC_EVEN  = 4; // even_parity_select
  localparam int LFC_PEN   = 3; // parity_on
  localparam int LFC_STOP  = 2; // stop_bit_count
  localparam int LFC_LEN_H = 1; // char_length_select msb
  // status field positions
  localparam int ST_RX_READY = 0;
  localparam int ST_PAR_ERR  = 1;
  localparam int ST_FRM_ERR  = 2;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_THR_EMPT = 5;
  localparam int ST_TX_IDLE  = 6;
  // reset values
  localparam logic [7:0]  LFC_RESET = 8'h00;
  localparam logic [7:0]  IER_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  // frame shape: data length in bits, timing in half-bit ticks
  localparam logic [2:0] MIN_LEN    = 3'h5; // shortest data word
  localparam logic [2:0] HALVES_BIT = 3'h2; // one whole bit
  localparam logic [2:0] HALVES_15  = 3'h3; // one and a half stop bits
  localparam logic [2:0] HALVES_2   = 3'h4; // two stop bits
  localparam logic [2:0] HALVES_MID = 3'h1; // start edge to start middle
endpackage : ulf_pkg
`default_nettype wire

// >>> verilog/ulf_parity.sv
// parity bit generator for one character, used for send and check
`default_nettype none
module ulf_parity #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] data,     // character, lsb first
  input  wire logic [1:0]   char_len, // 0..3 selects 5..8 bits
  input  wire logic         stick,    // stick_parity
  input  wire logic         even,     // even_parity_select
  output logic              par_bit   // parity bit to send or expect
);
  logic [W-1:0] mask; // keeps only the live data bits
  always_comb begin
    // unused upper bits must not count
    mask = {W{1'b1}} >> (2'd3 - char_len);
  end
  // stick picks a constant, otherwise odd or even count of ones
  assign par_bit = stick ? ~even : (^(data & mask)) ^ ~even;
endmodule : ulf_parity
`default_nettype wire

// >>> verilog/ulf_line_format.sv
// apb-reached line format control with the frame engine it steers
//
// Register access over APB and the address map were decided locally.
`default_nettype none
module ulf_line_format (
  input  wire logic        ref_clk,        // block clock, 50 MHz
  input  wire logic        rst_n,          // async reset, active low
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_in_pin,  // receive line, idle high
  output logic             serial_out_pin  // transmit line, idle high
);
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ulf_state_e;
  logic [7:0]  lfc_q;       // line_format_control
  logic [7:0]  ier_q;       // interrupt_enable_reg, stored only
  logic [15:0] div_q;       // divisor_high_reg : divisor_low_reg
  logic [7:0]  thr_q;       // tx_holding_reg
  logic        thr_full_q;  // holding register waits for the shifter
  logic [7:0]  rbr_q;       // rx_buffer_reg
  logic        rx_ready_q;  // rx_buffer_reg holds an unread character
  logic        par_err_q;   // sticky parity error
  logic        frm_err_q;   // sticky framing error
  logic        ovr_err_q;   // sticky overrun
  logic [31:0] prdata_q;    // read data, caught in the setup cycle
  logic        slverr_q;    // unmapped address flag, caught in setup
  logic        sout_q;      // registered serial output
  // format fields
  logic       das, brk, stick, even, pen, stb;
  logic [1:0] clen;
  assign das   = lfc_q[ulf_pkg::LFC_DAS];
  assign brk   = lfc_q[ulf_pkg::LFC_BRK];
  assign stick = lfc_q[ulf_pkg::LFC_STICK];
  assign even  = lfc_q[ulf_pkg::LFC_EVEN];
  assign pen   = lfc_q[ulf_pkg::LFC_PEN];
  assign stb   = lfc_q[ulf_pkg::LFC_STOP];
  assign clen  = lfc_q[ulf_pkg::LFC_LEN_H:0];
  // bus strobes
  logic setup, wr, rd, hit_data, hit_ier, hit_lfc, hit_st;
  assign setup    = psel & ~penable;
  assign wr       = psel & penable & pwrite;
  assign rd       = psel & penable & ~pwrite;
  assign hit_data = paddr == ulf_pkg::OFS_DATA;
  assign hit_ier  = paddr == ulf_pkg::OFS_IER;
  assign hit_lfc  = paddr == ulf_pkg::OFS_LFC;
  assign hit_st   = paddr == ulf_pkg::OFS_STATUS;
  // frame shape; the data length is shared by both directions, the stop length is used by transmit only
  logic [2:0] nbits, stop_halves;
  assign nbits       = ulf_pkg::MIN_LEN + {1'b0, clen};
  assign stop_halves = !stb ? ulf_pkg::HALVES_BIT : (clen == 2'b00) ? ulf_pkg::HALVES_15 : ulf_pkg::HALVES_2;
  // transmit engine state
  ulf_state_e tx_st_q;
  logic [15:0] tbc_q;   // half-bit divider for transmit
  logic [2:0]  th_q;    // half ticks spent in the current bit
  logic [2:0]  tidx_q;  // data bit index
  logic [7:0]  tsh_q;   // shift register
  logic [7:0]  tword_q; // copy of the character for parity
  logic        ttick, tbit_end, tx_par, tx_line;
  logic [2:0]  tneed;
  assign ttick    = tbc_q == div_q;
  assign tneed    = (tx_st_q == ST_STOP) ? stop_halves : ulf_pkg::HALVES_BIT;
  assign tbit_end = ttick && (th_q == tneed - 3'h1);
  ulf_parity #(.W(8)) u_tx_par (
    .data     (tword_q),
    .char_len (clen),
    .stick    (stick),
    .even     (even),
    .par_bit  (tx_par)
  );
  // line level the transmitter wants, before the break override
  always_comb begin
    unique case (tx_st_q)
      ST_START: tx_line = 1'b0;
      ST_DATA:  tx_line = tsh_q[0];
      ST_PAR:   tx_line = tx_par;
      default:  tx_line = 1'b1;
    endcase
  end
  // register writes; all format bits clear on reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfc_q <= ulf_pkg::LFC_RESET;
      ier_q <= ulf_pkg::IER_RESET;
      div_q <= ulf_pkg::DIV_RESET;
    end else if (wr) begin
      if (hit_lfc) begin
        lfc_q <= pwdata[7:0];
      end
      if (hit_data && das) begin
        div_q[7:0] <= pwdata[7:0];
      end
      if (hit_ier && das) begin
        div_q[15:8] <= pwdata[7:0];
      end else if (hit_ier) begin
        ier_q <= pwdata[7:0];
      end
    end
  end
  // holding register: written by software, emptied by the shifter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_q      <= 8'h00;
      thr_full_q <= 1'b0;
    end else if (wr && hit_data && !das) begin
      thr_q      <= pwdata[7:0];
      thr_full_q <= 1'b1;
    end else if (tx_st_q == ST_IDLE) begin
      thr_full_q <= 1'b0; // shifter takes it this cycle
    end
  end
  // transmit sequencer; runs on regardless of the break bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q <= ST_IDLE;
      tbc_q   <= 16'h0000;
      th_q    <= 3'h0;
      tidx_q  <= 3'h0;
      tsh_q   <= 8'h00;
      tword_q <= 8'h00;
    end else if (tx_st_q == ST_IDLE) begin
      // load a waiting character, even during a break
      tbc_q <= 16'h0000;
      th_q  <= 3'h0;
      if (thr_full_q) begin
        tsh_q   <= thr_q;
        tword_q <= thr_q;
        tidx_q  <= 3'h0;
        tx_st_q <= ST_START;
      end
    end else begin
      tbc_q <= ttick ? 16'h0000 : tbc_q + 16'h0001;
      if (ttick) begin
        th_q <= tbit_end ? 3'h0 : th_q + 3'h1;
      end
      if (tbit_end) begin
        unique case (tx_st_q)
          ST_START: tx_st_q <= ST_DATA;
          ST_DATA: begin
            tsh_q  <= tsh_q >> 1;
            tidx_q <= tidx_q + 3'h1;
            if (tidx_q == nbits - 3'h1) begin
              tx_st_q <= pen ? ST_PAR : ST_STOP;
            end
          end
          ST_PAR:  tx_st_q <= ST_STOP;
          default: tx_st_q <= ST_IDLE;
        endcase
      end
    end
  end
  // output pin; break forces spacing and nothing else
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sout_q <= 1'b1;
    end else begin
      sout_q <= brk ? 1'b0 : tx_line;
    end
  end
  assign serial_out_pin = sout_q;
  // receive engine state
  ulf_state_e rx_st_q;
  logic [15:0] rbc_q;   // half-bit divider, restarted at the start edge
  logic [2:0]  rh_q;    // half ticks spent in the current bit
  logic [2:0]  ridx_q;  // data bit index
  logic [7:0]  rword_q; // character being assembled
  logic        rpar_q;  // received parity bit
  logic        rtick, rbit_end, rx_par, rx_done;
  logic [2:0]  rneed;
  assign rtick    = rbc_q == div_q;
  assign rneed    = (rx_st_q == ST_START) ? ulf_pkg::HALVES_MID : ulf_pkg::HALVES_BIT;
  assign rbit_end = rtick && (rh_q == rneed - 3'h1);
  assign rx_done  = rbit_end && (rx_st_q == ST_STOP);
  ulf_parity #(.W(8)) u_rx_par (
    .data     (rword_q),
    .char_len (clen),
    .stick    (stick),
    .even     (even),
    .par_bit  (rx_par)
  );
  // receive sequencer: sample each bit at its middle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q <= ST_IDLE;
      rbc_q   <= 16'h0000;
      rh_q    <= 3'h0;
      ridx_q  <= 3'h0;
      rword_q <= 8'h00;
      rpar_q  <= 1'b0;
    end else if (rx_st_q == ST_IDLE) begin
      rbc_q <= 16'h0000;
      rh_q  <= 3'h0;
      if (!serial_in_pin) begin
        rword_q <= 8'h00;
        ridx_q  <= 3'h0;
        rx_st_q <= ST_START;
      end
    end else begin
      rbc_q <= rtick ? 16'h0000 : rbc_q + 16'h0001;
      if (rtick) begin
        rh_q <= rbit_end ? 3'h0 : rh_q + 3'h1;
      end
      if (rbit_end) begin
        unique case (rx_st_q)
          // a start that is high at its middle was a glitch
          ST_START: rx_st_q <= serial_in_pin ? ST_IDLE : ST_DATA;
          ST_DATA: begin
            rword_q[ridx_q] <= serial_in_pin;
            ridx_q          <= ridx_q + 3'h1;
            if (ridx_q == nbits - 3'h1) begin
              rx_st_q <= pen ? ST_PAR : ST_STOP;
            end
          end
          ST_PAR: begin
            rpar_q  <= serial_in_pin;
            rx_st_q <= ST_STOP;
          end
          default: rx_st_q <= ST_IDLE; // first stop bit only
        endcase
      end
    end
  end
  // receive flags; a new event wins over a clearing read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rbr_q      <= 8'h00;
      rx_ready_q <= 1'b0;
      par_err_q  <= 1'b0;
      frm_err_q  <= 1'b0;
      ovr_err_q  <= 1'b0;
    end else begin
      if (rd && hit_data && !das) begin
        rx_ready_q <= 1'b0;
      end
      if (rd && hit_st) begin
        par_err_q <= 1'b0;
        frm_err_q <= 1'b0;
        ovr_err_q <= 1'b0;
      end
      if (rx_done) begin
        rbr_q      <= rword_q;
        rx_ready_q <= 1'b1;
        if (rx_ready_q) begin
          ovr_err_q <= 1'b1;
        end
        if (pen && rpar_q != rx_par) begin
          par_err_q <= 1'b1;
        end
        if (!serial_in_pin) begin
          frm_err_q <= 1'b1;
        end
      end
    end
  end
  // read mux, captured in the setup cycle
  logic [31:0] rmux;
  logic [7:0]  stat;
  always_comb begin
    stat                      = 8'h00;
    stat[ulf_pkg::ST_RX_READY] = rx_ready_q;
    stat[ulf_pkg::ST_PAR_ERR]  = par_err_q;
    stat[ulf_pkg::ST_FRM_ERR]  = frm_err_q;
    stat[ulf_pkg::ST_OVERRUN]  = ovr_err_q;
    stat[ulf_pkg::ST_THR_EMPT] = ~thr_full_q;
    stat[ulf_pkg::ST_TX_IDLE]  = (tx_st_q == ST_IDLE) & ~thr_full_q;
    rmux = 32'h0000_0000;
    if (hit_data) begin
      rmux[7:0] = das ? div_q[7:0] : rbr_q;
    end else if (hit_ier) begin
      rmux[7:0] = das ? div_q[15:8] : ier_q;
    end else if (hit_lfc) begin
      rmux[7:0] = lfc_q;
    end else if (hit_st) begin
      rmux[7:0] = stat;
    end
  end
  // apb answer: one access cycle, error on unmapped address
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rmux;
      slverr_q <= ~(hit_data | hit_ier | hit_lfc | hit_st);
    end
  end
  assign prdata  = prdata_q;
  assign pready  = psel & penable;
  assign pslverr = psel & penable & slverr_q;
  // checks
  sequence tx_enter_stop;
    $changed(tx_st_q) && tx_st_q == ST_STOP;
  endsequence
  sequence tx_data_done;
    tbit_end && tx_st_q == ST_DATA && tidx_q == nbits - 3'h1;
  endsequence
  chk_break_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    brk |=> !serial_out_pin) else $error("break set but line not low");
  chk_break_only_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
    brk && tx_st_q == ST_IDLE && thr_full_q |=> tx_st_q == ST_START) else $error("break stalled the transmitter");
  chk_line_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !brk |=> serial_out_pin == $past(tx_line)) else $error("line not following transmitter");
  chk_divisor_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr && hit_data && das |=> div_q[7:0] == $past(pwdata[7:0]) && !$rose(thr_full_q)) else $error("divisor route");
  chk_data_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr && hit_data && !das |=> thr_full_q && $stable(div_q)) else $error("holding write misrouted");
  chk_stick_parity: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tx_st_q == ST_PAR && stick && pen && !brk |=> serial_out_pin == !even) else $error("stick parity wrong");
  chk_normal_parity: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tx_st_q == ST_PAR && !stick && clen == 2'b11 |-> (^{tword_q, tx_par}) == !even) else $error("parity count wrong");
  chk_parity_slot: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tx_data_done |=> tx_st_q == (pen ? ST_PAR : ST_STOP)) else $error("parity slot wrong");
  chk_stop_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tx_enter_stop |-> tneed == (!stb ? 3'h2 : (clen == 2'b00 ? 3'h3 : 3'h4))) else $error("stop length wrong");
  chk_reset_clear: assert property (@(posedge ref_clk)
    !$past(rst_n) && rst_n |-> lfc_q == 8'h00) else $error("format not cleared by reset");
endmodule : ulf_line_format
`default_nettype wire

// >>> bench/ulf_remote_model.sv
// remote serial transceiver model facing the line format block
`default_nettype none
module ulf_remote_model #(
  parameter int HALF = 4 // clocks per half bit, divisor plus one
) (
  input  wire logic ref_clk,  // shared clock
  input  wire logic line_in,  // from the block transmit line
  output logic      line_out  // to the block receive line
);
  timeunit 1ns;
  timeprecision 1ns;
  time last_start = 0; // time of previous start edge
  // line idles high between frames
  initial line_out = 1'b1;
  // hold the line at one level for a number of half bits
  task automatic drive(input logic v, input int halves);
    line_out <= v;
    repeat (halves * HALF) @(posedge ref_clk);
  endtask : drive
  // send one frame in the format that the block is set to
  task automatic send(input logic [7:0] d, input int nb, input bit pen, input logic p, input int sh);
    @(posedge ref_clk);
    drive(1'b0, 2);
    for (int i = 0; i < nb; i++) drive(d[i], 2);
    if (pen) drive(p, 2);
    drive(1'b1, sh);
  endtask : send
  // receive one frame, sampling each bit in its middle
  task automatic recv(input int nb, input bit pen, output logic [7:0] d, output logic p, output int gap);
    d = 8'h00;
    p = 1'b0;
    do @(posedge ref_clk); while (line_in !== 1'b0);
    gap = int'(($time - last_start) / 20);
    last_start = $time;
    repeat (HALF) @(posedge ref_clk);
    for (int i = 0; i < nb; i++) begin
      repeat (2 * HALF) @(posedge ref_clk);
      d[i] = line_in;
    end
    if (pen) begin
      repeat (2 * HALF) @(posedge ref_clk);
      p = line_in;
    end
    repeat (2 * HALF) @(posedge ref_clk);
  endtask : recv
endmodule : ulf_remote_model
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the line format control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 4; // half bit in clocks for divisor 3
  localparam logic [7:0] A_DAT = ulf_pkg::OFS_DATA;
  localparam logic [7:0] A_IER = ulf_pkg::OFS_IER;
  localparam logic [7:0] A_LFC = ulf_pkg::OFS_LFC;
  localparam logic [7:0] A_ST  = ulf_pkg::OFS_STATUS;
  localparam logic [7:0] ST_IDLE = 8'h01 << ulf_pkg::ST_THR_EMPT | 8'h01 << ulf_pkg::ST_TX_IDLE;
  localparam logic [7:0] TX_CFG [6] = '{8'h00, 8'h0D, 8'h1E, 8'h3B, 8'h2C, 8'h1B}; // formats sent
  localparam logic [7:0] TX_DAT [6] = '{8'hF5, 8'hA3, 8'h5C, 8'h96, 8'h13, 8'hFF};
  localparam logic [7:0] RX_CFG [7] = '{8'h1B, 8'h1B, 8'h3B, 8'h3B, 8'h2A, 8'h0A, 8'h00}; // formats received
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, rx_line, tx_line, e, p;
  logic [7:0]  paddr, c, dd, d;
  logic [31:0] pwdata, prdata, rd;
  int          err_total = 0, num_checks = 0, cycles = 0, gap, nb, sh, ex;
  ulf_line_format DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(rx_line), .serial_out_pin(tx_line));
  ulf_remote_model #(.HALF(HALF)) remote (.ref_clk(ref_clk), .line_in(tx_line), .line_out(rx_line));
  // free running clock, 20 ns period
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      $display("Error at %0t: run timed out", $time);
      report_and_stop();
    end
  end
  // counts, verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // compare a value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // compare a measured time against a window
  task automatic chk_range(input int got, input int lo, input int hi, input string what);
    num_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("Error at %0t: %s %0d outside %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : chk_range
  // one apb transfer: setup, then access until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    // wait for pready; there is no limit here, only the bench timeout ends a hang
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // read a register and compare it
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    xfer(1'b0, a, 8'h00);
    chk(rd, {24'h00_0000, exp}, what);
  endtask : rdc
  // poll status until the transmitter is idle
  task automatic wait_idle();
    do begin
      xfer(1'b0, A_ST, 8'h00);
    end while (rd[ulf_pkg::ST_TX_IDLE] !== 1'b1);
  endtask : wait_idle
  // expected parity bit of a character in a given format
  function automatic logic par_of(input logic [7:0] x, input logic [7:0] f);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - f[1:0]);
    return f[5] ? ~f[4] : (^(x & m)) ^ ~f[4];
  endfunction : par_of
  // main sequence
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk(tx_line, 1, "idle line");
    rdc(A_LFC, 8'h00, "format reset");
    rdc(A_IER, 8'h00, "ier reset");
    rdc(A_ST, ST_IDLE, "status reset");
    $display("test reset done");
    xfer(1'b1, A_LFC, 8'h80);
    xfer(1'b1, A_DAT, 8'h03);
    xfer(1'b1, A_IER, 8'h00);
    rdc(A_DAT, 8'h03, "divisor low");
    rdc(A_ST, ST_IDLE, "no send on divisor write");
    xfer(1'b1, A_LFC, 8'h00);
    xfer(1'b1, A_IER, 8'h0A);
    rdc(A_IER, 8'h0A, "ier");
    xfer(1'b1, A_LFC, 8'h80);
    rdc(A_IER, 8'h00, "divisor high");
    rdc(A_DAT, 8'h03, "divisor low kept");
    xfer(1'b1, A_LFC, 8'h00);
    xfer(1'b0, 8'h08, 8'h00);
    chk(e, 1, "unmapped error");
    chk(rd, 0, "unmapped read");
    $display("test select done");
    foreach (TX_CFG[i]) begin
      c  = TX_CFG[i];
      nb = 5 + c[1:0];
      sh = !c[2] ? 2 : (nb == 5 ? 3 : 4);
      ex = HALF * (2 * (1 + nb + c[3]) + sh);
      xfer(1'b1, A_LFC, c);
      fork
        begin
          xfer(1'b1, A_DAT, TX_DAT[i]);
          xfer(1'b1, A_DAT, ~TX_DAT[i]);
        end
        begin
          remote.recv(nb, c[3], d, p, gap);
          chk(d, TX_DAT[i] & (8'hFF >> (8 - nb)), "sent data");
          chk(p, c[3] & par_of(TX_DAT[i], c), "sent parity");
          remote.recv(nb, c[3], d, p, gap);
          chk(d, ~TX_DAT[i] & (8'hFF >> (8 - nb)), "second data");
          chk(p, c[3] & par_of(~TX_DAT[i], c), "second parity");
          chk_range(gap, ex, ex + 3, "frame period");
        end
      join
      wait_idle();
    end
    $display("test transmit done");
    xfer(1'b1, A_LFC, 8'h43);
    xfer(1'b1, A_DAT, 8'h55);
    repeat (20) begin
      @(posedge ref_clk);
      chk(tx_line, 0, "break level");
    end
    wait_idle();
    chk(rd, ST_IDLE, "send ran under break");
    chk(tx_line, 0, "break still held");
    xfer(1'b1, A_LFC, 8'h03);
    repeat (3) @(posedge ref_clk);
    chk(tx_line, 1, "break released");
    $display("test break done");
    foreach (RX_CFG[i]) begin
      c  = RX_CFG[i];
      nb = 5 + c[1:0];
      dd = 8'h5A + 8'(i);
      xfer(1'b1, A_LFC, c);
      remote.send(dd, nb, c[3], par_of(dd, c) ^ i[0], 2);
      rdc(A_ST, ST_IDLE | 8'h01 | {6'h00, c[3] & i[0], 1'b0}, "receive status");
      rdc(A_DAT, dd & (8'hFF >> (8 - nb)), "received data");
    end
    $display("test receive done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
